// ===== lpmrm_pkg.sv
// Constants, register map and state type of the low-power mode and reset manager.
// Assumes one 10 MHz clock and an APB master on the same clock.
// Overview of operation
// - Light sleep stops only the processor clock
// - Peripheral interrupt or event wakes light sleep
// - Deep stop gates core clocks and fast oscillators
// - Deep stop keeps every register except the external clock selection
// - Software picks regulator mode during deep stop
// - Any external line or clock line ends stop
// - Standby turns off regulator and fast oscillators
// - Standby loses state except standby circuitry
// - Reset pin, watchdog, wake pin, clock event exit
// - Real-time clock and watchdog keep their clocks
// - Regulator on after reset, low-power only stop
// - Hold reset while supervised supply is low
// - Power-on watches digital, power-down watches both
// - Option bit drops analog-supply power-down check
// - Internal oscillator is the clock after reset
// - External clock failure reverts clock and interrupts
// - Bus dividers keep both buses within limit
`default_nettype none

package lpmrm_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_HOLD_NS = 2000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRC_MHZ = 8;
  localparam int BUS_MAX_MHZ = 48;
  localparam int EXT_LINES_N = 16;

  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CLKDIV_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] ISTAT_OFS = 12'h00c;
  localparam logic [11:0] IMASK_OFS = 12'h010;

  localparam int CTRL_DEEP = 0;
  localparam int CTRL_STBY = 1;
  localparam int CTRL_LOWREG = 2;
  localparam int CTRL_PLL = 3;
  localparam int CTRL_EXT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;

  localparam int DIV_W = 3;
  localparam int AHB_DIV_LSB = 0;
  localparam int APB_DIV_LSB = 4;
  localparam logic [2:0] DIV_RST = 3'h0;

  localparam int IRQ_CSS = 0;
  localparam int IRQ_STOPWK = 1;
  localparam int IRQ_STBYWK = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [2:0] {S_RESET, S_RUN, S_SLEEP, S_STOP, S_STANDBY} lpmrm_state_t;
endpackage : lpmrm_pkg

`default_nettype wire

// ===== lpmrm_top.sv
// Power-mode and reset manager: state machine, clock and regulator controls, APB registers.
// Assumes pins and supervisor flags are asynchronous; core request pulses are on mclk.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`default_nettype none

module lpmrm_top
  import lpmrm_pkg::*;
#(
  parameter int EXT_MHZ = 32
)
(
  input wire logic mclk, // 10 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic core_sleep_req, // Core enters low power, pulse
  input wire logic periph_event, // Any peripheral interrupt or event
  input wire logic [EXT_LINES_N-1:0] external_interrupt_lines, // External interrupt lines, async
  input wire logic rtc_line, // Clock-calendar line, async
  input wire logic rtc_event, // Clock-calendar standby wake event, async
  input wire logic wakeup_pin, // Wake pin, async
  input wire logic external_reset_pin_n, // Reset pin, async, active low
  input wire logic independent_watchdog_reset, // Independent watchdog reset, async
  input wire logic por_vdd_ok, // Power-on supervisor digital supply good
  input wire logic power_down_supervisor_vdd_ok, // Power-down supervisor digital supply good
  input wire logic power_down_supervisor_analog_ok, // Power-down supervisor analog supply good
  input wire logic analog_supply_mon_off, // Option bit, skip analog supply check
  input wire logic ext_clk_fail, // Clock monitor failure flag, async
  output logic sys_rst_n, // System reset, active low
  output logic cpu_clk_en, // Processor clock gate
  output logic periph_clk_en, // Peripheral clock gate
  output logic core_clk_en, // Core-domain clock gate
  output logic pll_en, // Phase-locked loop enable
  output logic internal_fast_rc_oscillator_en, // Internal fast RC oscillator enable
  output logic external_crystal_oscillator_en, // External crystal oscillator enable
  output logic sysclk_ext, // System clock from external source
  output logic reg_on, // Regulator powered
  output logic reg_low_power, // Regulator in low-power mode
  output logic rtc_watchdog_clk_en, // Clock-calendar and watchdog clocks
  output logic ahb_ce, // High-speed bus clock enable pulse
  output logic apb_ce, // Peripheral bus clock enable pulse
  output logic irq // Interrupt, level
);
  localparam int MIN_DIV = (EXT_MHZ + BUS_MAX_MHZ - 1) / BUS_MAX_MHZ;
  localparam int NS = EXT_LINES_N + 10;
  localparam int I_RTCL = EXT_LINES_N;
  localparam int I_RTCE = EXT_LINES_N + 1;
  localparam int I_WK = EXT_LINES_N + 2;
  localparam int I_PIN = EXT_LINES_N + 3;
  localparam int I_WDG = EXT_LINES_N + 4;
  localparam int I_POR = EXT_LINES_N + 5;
  localparam int I_PDD = EXT_LINES_N + 6;
  localparam int I_PDA = EXT_LINES_N + 7;
  localparam int I_OPT = EXT_LINES_N + 8;
  localparam int I_CSS = EXT_LINES_N + 9;

  if (EXT_MHZ < 4 || EXT_MHZ > 32 || MIN_DIV > 8)
  begin : g_chk
    $error("EXT_MHZ out of range");
  end

  logic [NS-1:0] async_in;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  assign async_in = {ext_clk_fail, analog_supply_mon_off, power_down_supervisor_analog_ok,
                     power_down_supervisor_vdd_ok, por_vdd_ok, independent_watchdog_reset,
                     external_reset_pin_n, wakeup_pin, rtc_event, rtc_line, external_interrupt_lines};

  for (genvar i = 0; i < NS; i++)
  begin : g_sync
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end
      else
      begin
        s1_q[i] <= async_in[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  logic wk_prev_q;
  logic wk_rise;
  logic supply_ok;
  logic hard_rst;
  logic external_interrupt_lines_any;
  logic css_fail;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wk_prev_q <= 1'b0;
    else
      wk_prev_q <= s2_q[I_WK];
  end
  assign wk_rise = s2_q[I_WK] & ~wk_prev_q;
  assign supply_ok = s2_q[I_POR] & s2_q[I_PDD] & (s2_q[I_PDA] | s2_q[I_OPT]);
  assign hard_rst = ~supply_ok | ~s2_q[I_PIN] | s2_q[I_WDG];
  assign external_interrupt_lines_any = (|s2_q[EXT_LINES_N-1:0]) | s2_q[I_RTCL];
  assign css_fail = s2_q[I_CSS];

  lpmrm_state_t state_q;
  lpmrm_state_t state_d;
  logic [15:0] hold_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] imask_q;
  logic [DIV_W-1:0] ahb_div_q;
  logic [DIV_W-1:0] apb_div_q;
  logic ext_sel_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_RESET:
        if (!hard_rst && hold_q >= 16'(RST_HOLD_CYC - 1))
          state_d = S_RUN;
      S_RUN:
        if (core_sleep_req)
        begin
          if (!ctrl_q[CTRL_DEEP])
            state_d = S_SLEEP;
          else if (ctrl_q[CTRL_STBY])
            state_d = S_STANDBY;
          else
            state_d = S_STOP;
        end
      S_SLEEP:
        if (periph_event || external_interrupt_lines_any)
          state_d = S_RUN;
      S_STOP:
        if (external_interrupt_lines_any)
          state_d = S_RUN;
      S_STANDBY:
        if (wk_rise || s2_q[I_RTCE])
          state_d = S_RESET;
      default:
        state_d = S_RESET;
    endcase
    if (hard_rst)
      state_d = S_RESET;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= S_RESET;
    else
      state_q <= state_d;
  end

  // Reset release waits for a quiet supply for the hold time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= 16'h0000;
    else if (state_q != S_RESET || hard_rst)
      hold_q <= 16'h0000;
    else if (hold_q != 16'hffff)
      hold_q <= hold_q + 16'h0001;
  end

  logic setup;
  logic wr;
  logic hit;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;
  assign hit = paddr == CTRL_OFS || paddr == CLKDIV_OFS || paddr == STAT_OFS ||
               paddr == ISTAT_OFS || paddr == IMASK_OFS;

  // Registers are cleared only by the reset state; stop leaves them alone
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      imask_q <= IRQ_RST;
      ahb_div_q <= DIV_RST;
      apb_div_q <= DIV_RST;
    end
    else if (state_q == S_RESET)
    begin
      ctrl_q <= CTRL_RST;
      imask_q <= IRQ_RST;
      ahb_div_q <= DIV_RST;
      apb_div_q <= DIV_RST;
    end
    else if (wr && !pslverr)
    begin
      if (paddr == CTRL_OFS)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == IMASK_OFS)
        imask_q <= pwdata[IRQ_W-1:0];
      if (paddr == CLKDIV_OFS)
      begin
        ahb_div_q <= pwdata[AHB_DIV_LSB +: DIV_W];
        apb_div_q <= pwdata[APB_DIV_LSB +: DIV_W];
      end
    end
  end

  // External clock selection: software sets it, failure or stop drops it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ext_sel_q <= 1'b0;
    else if (state_q == S_RESET)
      ext_sel_q <= 1'b0;
    else if (css_fail || state_q == S_STOP)
      ext_sel_q <= 1'b0;
    else if (wr && paddr == CTRL_OFS)
      ext_sel_q <= pwdata[CTRL_EXT];
  end

  // Sticky flags live in the standby circuitry; a new event wins over a clear
  logic [IRQ_W-1:0] ev;
  assign ev = {state_q == S_STANDBY && state_d == S_RESET,
               state_q == S_STOP && state_d == S_RUN,
               ext_sel_q && css_fail};
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      istat_q <= IRQ_RST;
    else if (wr && paddr == ISTAT_OFS)
      istat_q <= (istat_q & ~pwdata[IRQ_W-1:0]) | ev;
    else
      istat_q <= istat_q | ev;
  end

  // APB answers in the first access cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          CTRL_OFS: prdata[CTRL_W-1:0] <= {ext_sel_q, ctrl_q[CTRL_W-2:0]};
          CLKDIV_OFS: prdata <= {25'h0, apb_div_q, 1'b0, ahb_div_q};
          STAT_OFS: prdata[3:0] <= {ext_sel_q, state_q};
          ISTAT_OFS: prdata[IRQ_W-1:0] <= istat_q;
          IMASK_OFS: prdata[IRQ_W-1:0] <= imask_q;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Bus dividers raised to the least ratio that keeps the bus in limit
  logic [DIV_W-1:0] ahb_eff;
  logic [DIV_W-1:0] apb_eff;
  logic [DIV_W-1:0] ahb_cnt_q;
  logic [DIV_W-1:0] apb_cnt_q;
  localparam logic [DIV_W-1:0] MIN_FIELD = DIV_W'(MIN_DIV - 1);
  assign ahb_eff = (ext_sel_q && ahb_div_q < MIN_FIELD) ? MIN_FIELD : ahb_div_q;
  assign apb_eff = (ext_sel_q && ahb_eff == 3'h0 && apb_div_q < MIN_FIELD) ? MIN_FIELD : apb_div_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ahb_cnt_q <= 3'h0;
      apb_cnt_q <= 3'h0;
      ahb_ce <= 1'b0;
      apb_ce <= 1'b0;
    end
    else
    begin
      ahb_ce <= ahb_cnt_q == 3'h0 && core_clk_en;
      apb_ce <= ahb_cnt_q == 3'h0 && apb_cnt_q == 3'h0 && core_clk_en;
      ahb_cnt_q <= (ahb_cnt_q >= ahb_eff) ? 3'h0 : ahb_cnt_q + 3'h1;
      if (ahb_cnt_q == 3'h0)
        apb_cnt_q <= (apb_cnt_q >= apb_eff) ? 3'h0 : apb_cnt_q + 3'h1;
    end
  end

  // Power and clock outputs follow the next state so they line up with state_q
  logic lowp_d;
  assign lowp_d = state_d == S_STOP || state_d == S_STANDBY;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_rst_n <= 1'b0;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      core_clk_en <= 1'b0;
      pll_en <= 1'b0;
      internal_fast_rc_oscillator_en <= 1'b1;
      external_crystal_oscillator_en <= 1'b0;
      sysclk_ext <= 1'b0;
      reg_on <= 1'b1;
      reg_low_power <= 1'b0;
      rtc_watchdog_clk_en <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      sys_rst_n <= state_d != S_RESET;
      cpu_clk_en <= state_d == S_RUN;
      periph_clk_en <= state_d == S_RUN || state_d == S_SLEEP;
      core_clk_en <= state_d == S_RUN || state_d == S_SLEEP;
      pll_en <= ctrl_q[CTRL_PLL] && !lowp_d && state_d != S_RESET;
      internal_fast_rc_oscillator_en <= !lowp_d;
      external_crystal_oscillator_en <= ext_sel_q && !css_fail && !lowp_d && state_d != S_RESET;
      sysclk_ext <= ext_sel_q && !css_fail && state_d != S_RESET;
      reg_on <= state_d != S_STANDBY;
      reg_low_power <= state_d == S_STOP && ctrl_q[CTRL_LOWREG];
      rtc_watchdog_clk_en <= 1'b1;
      irq <= |((istat_q | ev) & imask_q);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_stby_wake;
    state_q == S_STANDBY && !hard_rst && (wk_rise || s2_q[I_RTCE]);
  endsequence
  sequence s_restart;
    !sys_rst_n && !reg_low_power && !sysclk_ext ##1 !sys_rst_n;
  endsequence

  property p_sleep_clk;
    state_q == S_SLEEP |-> !cpu_clk_en && periph_clk_en && core_clk_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock gating wrong");

  property p_sleep_wake;
    state_q == S_SLEEP && periph_event && !hard_rst |=> state_q == S_RUN && cpu_clk_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

  property p_stop_off;
    state_q == S_STOP |-> !core_clk_en && !pll_en && !internal_fast_rc_oscillator_en &&
      !external_crystal_oscillator_en;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop left a clock running");

  property p_stop_keep;
    state_q == S_STOP && !pready |=> $stable(ctrl_q) && $stable(imask_q);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop lost register state");

  property p_stop_reg;
    state_q == S_STOP && $stable(ctrl_q) |-> reg_on && reg_low_power == ctrl_q[CTRL_LOWREG];
  endproperty
  a_stop_reg: assert property (p_stop_reg) else $error("stop regulator mode wrong");

  property p_stop_wake;
    state_q == S_STOP && s2_q[0] && !hard_rst |=> state_q == S_RUN ##0 istat_q[IRQ_STOPWK];
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop did not wake");

  property p_stby_off;
    state_q == S_STANDBY |-> !reg_on && !pll_en && !internal_fast_rc_oscillator_en &&
      !external_crystal_oscillator_en;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby left power on");

  property p_stby_wake;
    s_stby_wake |=> s_restart;
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake not a reset");

  property p_rtc_clk;
    state_q == S_STOP || state_q == S_STANDBY |-> rtc_watchdog_clk_en;
  endproperty
  a_rtc_clk: assert property (p_rtc_clk) else $error("clock-calendar clock stopped");

  property p_lpr_only_stop;
    state_q != S_STOP |-> !reg_low_power && (reg_on || state_q == S_STANDBY);
  endproperty
  a_lpr_only_stop: assert property (p_lpr_only_stop) else $error("low-power regulator outside stop");

  property p_supply_hold;
    !supply_ok |=> !sys_rst_n [*2];
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("reset released on low supply");

  property p_css;
    sysclk_ext && css_fail |=> !sysclk_ext && istat_q[IRQ_CSS] ##1 (irq == imask_q[IRQ_CSS]);
  endproperty
  a_css: assert property (p_css) else $error("clock failure not handled");

  property p_boot_clk;
    $rose(sys_rst_n) |-> !sysclk_ext && internal_fast_rc_oscillator_en;
  endproperty
  a_boot_clk: assert property (p_boot_clk) else $error("reset clock not internal");
endmodule : lpmrm_top

`default_nettype wire

// ===== lpmrm_core_model.sv
// Core-side partner: turns bench commands into sleep requests and peripheral events.
// Assumes the manager's mclk; a halted core cannot issue a request.
`default_nettype none

module lpmrm_core_model (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic cpu_clk_en, // Processor clock gate
  input wire logic sleep_cmd, // Bench asks the core to sleep
  input wire logic event_cmd, // Bench asks a peripheral to signal
  output logic core_sleep_req, // Sleep request pulse
  output logic periph_event // Peripheral event
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_sleep_req <= 1'b0;
      periph_event <= 1'b0;
    end
    else
    begin
      core_sleep_req <= sleep_cmd & cpu_clk_en;
      periph_event <= event_cmd;
    end
  end
endmodule : lpmrm_core_model

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the power-mode and reset manager.
// Assumes the core partner model and an APB master on mclk.
`default_nettype none

module tb;
  import lpmrm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic core_sleep_req, periph_event, sleep_cmd, event_cmd;
  logic [EXT_LINES_N-1:0] external_interrupt_lines;
  logic rtc_line, rtc_event, wakeup_pin, external_reset_pin_n, independent_watchdog_reset;
  logic por_vdd_ok, power_down_supervisor_vdd_ok, power_down_supervisor_analog_ok;
  logic analog_supply_mon_off, ext_clk_fail;
  logic sys_rst_n, cpu_clk_en, periph_clk_en, core_clk_en, pll_en;
  logic internal_fast_rc_oscillator_en, external_crystal_oscillator_en;
  logic sysclk_ext, reg_on, reg_low_power, rtc_watchdog_clk_en, ahb_ce, apb_ce, irq;
  int bad_count = 0;
  int n_checks = 0;

  lpmrm_top i_lpmrm_top (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_sleep_req, .periph_event, .external_interrupt_lines, .rtc_line, .rtc_event,
    .wakeup_pin, .external_reset_pin_n, .independent_watchdog_reset, .por_vdd_ok,
    .power_down_supervisor_vdd_ok, .power_down_supervisor_analog_ok, .analog_supply_mon_off,
    .ext_clk_fail, .sys_rst_n, .cpu_clk_en, .periph_clk_en, .core_clk_en, .pll_en,
    .internal_fast_rc_oscillator_en, .external_crystal_oscillator_en, .sysclk_ext, .reg_on,
    .reg_low_power, .rtc_watchdog_clk_en, .ahb_ce, .apb_ce, .irq);
  lpmrm_core_model i_lpmrm_core_model (.mclk, .rst_n, .cpu_clk_en, .sleep_cmd, .event_cmd,
    .core_sleep_req, .periph_event);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
      chk("pready", 1, 0);
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  function automatic logic sig(input int s);
    case (s)
      0: return sys_rst_n;
      1: return cpu_clk_en;
      2: return core_clk_en;
      3: return sysclk_ext;
      default: return reg_on;
    endcase
  endfunction : sig

  // Bounded wait for a manager output to reach a level
  task automatic wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 200 && sig(s) !== v; i++)
      @(posedge mclk);
    chk("wait level", v, sig(s));
  endtask : wait_for

  task automatic cmd_sleep();
    @(posedge mclk);
    sleep_cmd <= 1'b1;
    @(posedge mclk);
    sleep_cmd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : cmd_sleep

  task automatic t_reset();
    chk("sys_rst_n in reset", 0, sys_rst_n);
    chk("reg_on in reset", 1, reg_on);
    chk("fast rc in reset", 1, internal_fast_rc_oscillator_en);
    rst_n <= 1'b1;
    wait_for(0, 1'b1);
    chk("reg_on", 1, reg_on);
    chk("reg_low_power", 0, reg_low_power);
    chk("sysclk_ext", 0, sysclk_ext);
    chk("rtc_watchdog_clk_en", 1, rtc_watchdog_clk_en);
    rchk("stat", STAT_OFS, 32'h1);
  endtask : t_reset

  task automatic t_sleep();
    apb(1'b1, CTRL_OFS, 32'h0);
    cmd_sleep();
    chk("cpu_clk_en sleep", 0, cpu_clk_en);
    chk("periph_clk_en sleep", 1, periph_clk_en);
    chk("core_clk_en sleep", 1, core_clk_en);
    rchk("stat sleep", STAT_OFS, 32'h2);
    @(posedge mclk);
    event_cmd <= 1'b1;
    @(posedge mclk);
    event_cmd <= 1'b0;
    wait_for(1, 1'b1);
  endtask : t_sleep

  task automatic t_div();
    int na;
    int nb;
    na = 0;
    nb = 0;
    apb(1'b1, CLKDIV_OFS, 32'h12);
    repeat (6) @(posedge mclk);
    repeat (60)
    begin
      @(posedge mclk);
      na += int'(ahb_ce);
      nb += int'(apb_ce);
    end
    chk("ahb pulses", 20, na);
    chk("apb pulses", 10, nb);
  endtask : t_div

  // Every external line and the clock line wake stop, both regulator modes
  task automatic t_stop();
    logic [31:0] v;
    for (int k = 0; k <= EXT_LINES_N; k++)
    begin
      v = k[0] ? 32'hd : 32'h9;
      apb(1'b1, CTRL_OFS, v);
      cmd_sleep();
      chk("core_clk_en stop", 0, core_clk_en);
      chk("oscillators stop", 0, {pll_en, internal_fast_rc_oscillator_en, external_crystal_oscillator_en});
      chk("reg_low_power stop", k[0], reg_low_power);
      chk("reg_on stop", 1, reg_on);
      chk("rtc_watchdog_clk_en stop", 1, rtc_watchdog_clk_en);
      @(posedge mclk);
      if (k < EXT_LINES_N)
        external_interrupt_lines[k] <= 1'b1;
      else
        rtc_line <= 1'b1;
      wait_for(2, 1'b1);
      external_interrupt_lines <= '0;
      rtc_line <= 1'b0;
      chk("reg_low_power run", 0, reg_low_power);
      chk("pll_en kept", 1, pll_en);
      rchk("ctrl kept", CTRL_OFS, v);
      rchk("clkdiv kept", CLKDIV_OFS, 32'h12);
      rchk("stop wake flag", ISTAT_OFS, 32'h2);
      apb(1'b1, ISTAT_OFS, 32'h2);
    end
  endtask : t_stop

  task automatic t_clkfail();
    apb(1'b1, IMASK_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h10);
    rchk("stat ext", STAT_OFS, 32'h9);
    chk("crystal on", 1, external_crystal_oscillator_en);
    @(posedge mclk);
    ext_clk_fail <= 1'b1;
    wait_for(3, 1'b0);
    ext_clk_fail <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("irq on failure", 1, irq);
    chk("crystal off on failure", 0, external_crystal_oscillator_en);
    chk("fast rc on failure", 1, internal_fast_rc_oscillator_en);
    rchk("fail flag", ISTAT_OFS, 32'h1);
    apb(1'b1, IMASK_OFS, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq masked", 0, irq);
    apb(1'b1, ISTAT_OFS, 32'h1);
    rchk("fail flag cleared", ISTAT_OFS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 1, rerr);
    chk("unmapped data", 0, rd);
  endtask : t_clkfail

  // Rows: digital good, power-down digital, analog good, option bit, expected sys_rst_n
  task automatic t_supply();
    logic [4:0] rows [4] = '{5'b01100, 5'b10100, 5'b11000, 5'b11011};
    foreach (rows[r])
    begin
      @(posedge mclk);
      {por_vdd_ok, power_down_supervisor_vdd_ok, power_down_supervisor_analog_ok,
       analog_supply_mon_off} <= rows[r][4:1];
      repeat (40) @(posedge mclk);
      chk("supply reset", rows[r][0], sys_rst_n);
      {por_vdd_ok, power_down_supervisor_vdd_ok, power_down_supervisor_analog_ok,
       analog_supply_mon_off} <= 4'b1110;
      repeat (4) @(posedge mclk);
      wait_for(0, 1'b1);
    end
  endtask : t_supply

  task automatic t_stby();
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, CLKDIV_OFS, 32'h5);
      apb(1'b1, CTRL_OFS, 32'h3);
      cmd_sleep();
      chk("reg_on standby", 0, reg_on);
      chk("oscillators standby", 0, {pll_en, internal_fast_rc_oscillator_en, external_crystal_oscillator_en});
      chk("rtc_watchdog_clk_en standby", 1, rtc_watchdog_clk_en);
      @(posedge mclk);
      case (c)
        0: wakeup_pin <= 1'b1;
        1: rtc_event <= 1'b1;
        2: external_reset_pin_n <= 1'b0;
        default: independent_watchdog_reset <= 1'b1;
      endcase
      repeat (4) @(posedge mclk);
      {wakeup_pin, rtc_event, external_reset_pin_n, independent_watchdog_reset} <= 4'b0010;
      wait_for(4, 1'b1);
      wait_for(0, 1'b1);
      chk("reg_low_power wake", 0, reg_low_power);
      rchk("ctrl lost", CTRL_OFS, 32'h0);
      rchk("clkdiv lost", CLKDIV_OFS, 32'h0);
      if (c < 2)
        rchk("standby wake flag", ISTAT_OFS, 32'h4);
      apb(1'b1, ISTAT_OFS, 32'h4);
    end
  endtask : t_stby

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_cmd, event_cmd, external_interrupt_lines, rtc_line, rtc_event, wakeup_pin} = '0;
    {independent_watchdog_reset, analog_supply_mon_off, ext_clk_fail} = '0;
    {external_reset_pin_n, por_vdd_ok, power_down_supervisor_vdd_ok, power_down_supervisor_analog_ok} = 4'hf;
    repeat (5) @(posedge mclk);
    t_reset();
    t_sleep();
    t_div();
    t_stop();
    t_clkfail();
    t_supply();
    t_stby();
    tally_and_finish();
  end

  initial
  begin
    #(20000 * 100);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
